/* File: och_pkg.sv */
// Constants and types for the overcurrent hiccup controller
package och_pkg;

  // ----------------------------------------
  // Clock and base timings
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SW_FREQ_KHZ = 600;
  localparam int POR_DELAY_US = 6800;
  localparam int SS_TIME_US = 6800;
  localparam int SS_STEPS = 64;
  localparam int SAMPLE_MAX_US = 3400;
  localparam int BLANK_NS = 200;
  localparam int MIN_LOW_NS = 425;
  localparam int NARROW_LIMIT = 3;
  localparam int HICCUP_DUMMIES = 2;
  localparam int TRIP_GAIN = 2;

  // ----------------------------------------
  // Trip level DAC
  // ----------------------------------------
  localparam int DAC_W = 8;
  localparam int DAC_LSB_UV = 2000;
  localparam int GUARD_OFF_MV = 300;
  localparam int GUARD_OFF_CODE = GUARD_OFF_MV * 1000 / DAC_LSB_UV;

  // ----------------------------------------
  // Derived cycle counts
  // ----------------------------------------
  localparam int SW_PERIOD_CYC = CLK_MHZ * 1000 / SW_FREQ_KHZ;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam int SS_STEP_CYC = SS_TIME_US * CLK_MHZ / SS_STEPS;
  localparam int SAMPLE_STEP_CYC = SAMPLE_MAX_US * CLK_MHZ / (2 ** DAC_W);
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_LOW_CYC = (MIN_LOW_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DAC_W-1:0] TRIP_LEVEL_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DELAY = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_SOFT = 3'h2,
    ST_RUN = 3'h6,
    ST_DUMMY = 3'h7
  } och_fsm_type;

endpackage

/* File: och_overcurrent_hiccup.sv */
// Overcurrent guard with trip-level sampling, blanked window and hiccup retry
//
// Contract
// - Trip shuts output off at once.
// - Trip: two dummy time-outs, then one soft-start.
// - Hiccup repeats forever, never latches off.
// - Sample trip level after power-on and delay.
// - Low gate off while sampling trip level.
// - Trip level held digitally in DAC counter.
// - Level kept; replaced only by post-shutdown sample.
// - Monitoring starts after blanking past low-gate rise.
// - Monitoring ends with low gate; trips anytime inside.
// - Third consecutive narrow low pulse stretched minimum.
// - Compare sensed drop with twice trip level.
// - Trip level above bound disables the guard.
// - Trip during retry soft-start restarts dummy phase.
// - Hiccup period between two and three soft-start spans.
// - Fault removed: soft-start completes, stays regulating.
// - Guard active in every soft-start, same retry.
// - Each trip starts new dummy pair immediately.
// - Fixed switching period from internal oscillator.
// - Other timings independent of switching clock.
// - No new sample during retries.
// - Re-enable repeats full init with sample.
// - Soft-start ramp in equal discrete steps.
`timescale 1ns/1ns
module och_overcurrent_hiccup #(
  parameter int POR_CYC = och_pkg::POR_DELAY_CYC,
  parameter int STEP_CYC = och_pkg::SS_STEP_CYC,
  parameter int SAMPLE_CYC = och_pkg::SAMPLE_STEP_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Supply and enable status pins
  input wire logic bias_supply_ok_i,
  input wire logic enable_i,
  // Trip-level sampling comparator pin, high while pin above DAC
  input wire logic trip_set_cmp_i,
  // Sensed switch drop and duty request, same clock domain
  input wire logic [och_pkg::DAC_W:0] sense_code_i,
  input wire logic [8:0] duty_i,
  // Gate drive
  output logic high_gate_o,
  output logic low_gate_o,
  // Status
  output logic trip_reference_current_o,
  output logic [och_pkg::DAC_W-1:0] trip_level_o,
  output logic [6:0] ramp_step_o,
  output logic output_on_o,
  output logic guard_disabled_o,
  output logic hiccup_o,
  output logic trip_o
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    och_pkg::och_fsm_type st;
    logic [31:0] timer;
    logic [6:0] step;
    logic dummy;
    logic [och_pkg::DAC_W-1:0] trip_level;
    logic guard_off;
    logic [8:0] phase;
    logic [8:0] duty;
    logic [1:0] narrow;
    logic [6:0] blank;
    logic high_gate;
    logic low_gate;
    logic run;
    logic trip_evt;
  } och_state_type;

  och_state_type s;
  och_state_type next_s;

  localparam logic [8:0] PERIOD = 9'(och_pkg::SW_PERIOD_CYC);
  localparam logic [8:0] MIN_LOW = 9'(och_pkg::MIN_LOW_CYC);
  localparam logic [6:0] BLANK = 7'(och_pkg::BLANK_CYC);
  localparam logic [6:0] LAST_STEP = 7'(och_pkg::SS_STEPS - 1);

  function automatic logic hit(input logic [31:0] t, input int lim);
    return t == 32'(lim - 1);
  endfunction

  logic por_ok;
  logic en_ok;
  logic cmp_hi;
  logic window;
  logic over;
  logic [8:0] d_req;

  assign por_ok = s.sync2[0];
  assign en_ok = s.sync2[1];
  assign cmp_hi = s.sync2[2];
  // Blanking hides gate-transition ringing before sensing
  assign window = s.low_gate && (s.blank == BLANK);
  assign over = sense_code_i > {s.trip_level, 1'b0};

  always_comb begin
    next_s = s;
    next_s.trip_evt = 1'b0;
    next_s.sync1 = {trip_set_cmp_i, enable_i, bias_supply_ok_i};
    next_s.sync2 = s.sync1;
    d_req = (duty_i > PERIOD) ? PERIOD : duty_i;

    // ----------------------------------------
    // Switching period and narrow pulse handling
    // ----------------------------------------
    if (s.phase == PERIOD - 9'h001) begin
      next_s.phase = 9'h000;
      if ((PERIOD - d_req) < MIN_LOW) begin
        if (s.narrow == 2'(och_pkg::NARROW_LIMIT - 1)) begin
          next_s.duty = PERIOD - MIN_LOW;
          next_s.narrow = 2'h0;
        end else begin
          next_s.duty = d_req;
          next_s.narrow = s.narrow + 2'h1;
        end
      end else begin
        next_s.duty = d_req;
        next_s.narrow = 2'h0;
      end
    end else begin
      next_s.phase = s.phase + 9'h001;
    end

    if (!s.low_gate) begin
      next_s.blank = 7'h00;
    end else if (s.blank != BLANK) begin
      next_s.blank = s.blank + 7'h01;
    end

    // ----------------------------------------
    // Sequencer, timed from the system clock only
    // ----------------------------------------
    next_s.timer = s.timer + 32'h1;
    if (!por_ok || !en_ok) begin
      // Leaving shutdown always goes through a fresh sample
      next_s.st = och_pkg::ST_OFF;
      next_s.timer = 32'h0;
      next_s.step = 7'h00;
      next_s.dummy = 1'b0;
    end else begin
      case (s.st)
        och_pkg::ST_OFF: begin
          next_s.st = och_pkg::ST_DELAY;
          next_s.timer = 32'h0;
        end
        och_pkg::ST_DELAY: begin
          if (hit(s.timer, POR_CYC)) begin
            next_s.st = och_pkg::ST_SAMPLE;
            next_s.timer = 32'h0;
            next_s.trip_level = och_pkg::TRIP_LEVEL_RST;
          end
        end
        och_pkg::ST_SAMPLE: begin
          if (hit(s.timer, SAMPLE_CYC)) begin
            next_s.timer = 32'h0;
            if (cmp_hi && (s.trip_level != {och_pkg::DAC_W{1'b1}})) begin
              next_s.trip_level = s.trip_level + 8'h01;
            end else begin
              next_s.st = och_pkg::ST_SOFT;
              next_s.step = 7'h00;
              next_s.guard_off = s.trip_level > 8'(och_pkg::GUARD_OFF_CODE);
            end
          end
        end
        och_pkg::ST_SOFT: begin
          if (hit(s.timer, STEP_CYC)) begin
            next_s.timer = 32'h0;
            next_s.step = s.step + 7'h01;
            if (s.step == LAST_STEP) begin
              next_s.st = och_pkg::ST_RUN;
            end
          end
        end
        och_pkg::ST_RUN: begin
          next_s.timer = 32'h0;
        end
        och_pkg::ST_DUMMY: begin
          if (hit(s.timer, STEP_CYC)) begin
            next_s.timer = 32'h0;
            next_s.step = s.step + 7'h01;
            if (s.step == LAST_STEP) begin
              next_s.step = 7'h00;
              next_s.dummy = ~s.dummy;
              if (s.dummy == 1'(och_pkg::HICCUP_DUMMIES - 1)) begin
                // Retry reuses the held level, no resample
                next_s.st = och_pkg::ST_SOFT;
              end
            end
          end
        end
        default: begin
          next_s.st = och_pkg::ST_OFF;
        end
      endcase

      // Guard live in every soft-start and in regulation
      if (s.run && window && over && !s.guard_off) begin
        next_s.st = och_pkg::ST_DUMMY;
        next_s.timer = 32'h0;
        next_s.step = 7'h00;
        next_s.dummy = 1'b0;
        next_s.trip_evt = 1'b1;
      end
    end

    // ----------------------------------------
    // Gate drive, dropped in the same edge as the trip
    // ----------------------------------------
    next_s.run = (next_s.st == och_pkg::ST_SOFT) || (next_s.st == och_pkg::ST_RUN);
    next_s.high_gate = next_s.run && (next_s.phase < next_s.duty);
    next_s.low_gate = next_s.run && !(next_s.phase < next_s.duty);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign high_gate_o = s.high_gate;
  assign low_gate_o = s.low_gate;
  assign trip_reference_current_o = (s.st == och_pkg::ST_DELAY) || (s.st == och_pkg::ST_SAMPLE);
  assign trip_level_o = s.trip_level;
  assign ramp_step_o = s.step;
  assign output_on_o = s.run;
  assign guard_disabled_o = s.guard_off;
  assign hiccup_o = s.st == och_pkg::ST_DUMMY;
  assign trip_o = s.trip_evt;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_trip_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s.trip_evt |-> (s.st == och_pkg::ST_DUMMY) && !s.low_gate && !s.high_gate;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("Gates still on after trip");

  property p_two_dummies;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (s.st == och_pkg::ST_DUMMY) ##1 (s.st == och_pkg::ST_SOFT) |-> $past(s.dummy, 1) && ($past(s.step, 1) == LAST_STEP);
  endproperty
  a_two_dummies: assert property (p_two_dummies) else $error("Retry left dummy phase early");

  property p_level_held;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (s.st != och_pkg::ST_SAMPLE) && ($past(s.st) != och_pkg::ST_SAMPLE) && ($past(s.st) != och_pkg::ST_DELAY)
        |-> $stable(s.trip_level);
  endproperty
  a_level_held: assert property (p_level_held) else $error("Trip level changed outside sampling");

  property p_guard_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s.guard_off |-> !s.trip_evt;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("Trip while guard disabled");

  property p_blank;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s.trip_evt |-> $past(s.low_gate, 1) && $past(s.low_gate, 51);
  endproperty
  a_blank: assert property (p_blank) else $error("Trip inside blanking interval");

  property p_sample_gate;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (s.st == och_pkg::ST_DELAY || s.st == och_pkg::ST_SAMPLE) |-> !s.low_gate && trip_reference_current_o;
  endproperty
  a_sample_gate: assert property (p_sample_gate) else $error("Low gate on during sampling");

  property p_stretch;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (s.phase == PERIOD - 9'h001) && (s.narrow == 2'h2) && ((PERIOD - d_req) < MIN_LOW)
        |=> s.duty == PERIOD - MIN_LOW;
  endproperty
  a_stretch: assert property (p_stretch) else $error("Third narrow pulse not stretched");

  property p_restart;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s.trip_evt |-> (s.timer == 32'h0) && (s.step == 7'h00) && !s.dummy;
  endproperty
  a_restart: assert property (p_restart) else $error("Dummy pair not restarted on trip");

  property p_compare;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s.trip_evt |-> $past(sense_code_i) > {$past(s.trip_level), 1'b0};
  endproperty
  a_compare: assert property (p_compare) else $error("Trip below twice the level");

  // Both switches stay dark so the power stage can cool
  property p_dummy_dark;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (s.st == och_pkg::ST_DUMMY) |-> !s.high_gate && !s.low_gate && !s.run;
  endproperty
  a_dummy_dark: assert property (p_dummy_dark) else $error("Output on during dummy time-out");

  property p_disable;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !s.sync2[1] |=> (s.st == och_pkg::ST_OFF) && !s.run;
  endproperty
  a_disable: assert property (p_disable) else $error("Output still on after enable dropped");

endmodule

/* File: och_load_model.sv */
// Far-side model: trip-set pin network and low-side switch drop
`timescale 1ns/1ns
module och_load_model (
  // Gate and held level from the controller
  input wire logic low_gate_i,
  input wire logic [7:0] trip_level_i,
  // Scenario knobs
  input wire logic [7:0] set_code_i,
  input wire logic [8:0] load_code_i,
  // Sensed values to the controller
  output logic trip_set_cmp_o,
  output logic [8:0] sense_code_o
);
  // Pin voltage held by the resistor, compared against the DAC
  assign trip_set_cmp_o = set_code_i > trip_level_i;
  // No drop to sense while the low-side switch is off
  assign sense_code_o = low_gate_i ? load_code_i : 9'h000;
endmodule

/* File: och_overcurrent_hiccup_tb_top.sv */
// Self-checking bench for the overcurrent hiccup controller
`timescale 1ns/1ns
module och_overcurrent_hiccup_tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic bias_ok = 1'b0;
  logic en = 1'b0;
  logic [7:0] set_code = 8'h05;
  logic [8:0] load_code = 9'h000;
  logic [8:0] duty = 9'h0C8;
  logic cmp, hg, lg, irc, on, gd, hic, trip;
  logic [8:0] sense;
  logic [7:0] level;
  logic [6:0] ramp;
  int num_errors = 0;
  int compares = 0;

  always #2 sys_clk = ~sys_clk;

  // Small counts keep the run short
  och_overcurrent_hiccup #(.POR_CYC(20), .STEP_CYC(10), .SAMPLE_CYC(20)) dut (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .bias_supply_ok_i(bias_ok), .enable_i(en),
    .trip_set_cmp_i(cmp), .sense_code_i(sense), .duty_i(duty), .high_gate_o(hg), .low_gate_o(lg),
    .trip_reference_current_o(irc), .trip_level_o(level), .ramp_step_o(ramp), .output_on_o(on),
    .guard_disabled_o(gd), .hiccup_o(hic), .trip_o(trip));

  och_load_model model (.low_gate_i(lg), .trip_level_i(level), .set_code_i(set_code),
    .load_code_i(load_code), .trip_set_cmp_o(cmp), .sense_code_o(sense));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic final_report;
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Low-side high width and rise-to-rise period
  task automatic measure(output int hi, output int per);
    int i;
    i = 0; hi = 0; per = 0;
    while (lg !== 1'b0 && i < 3000) begin @(negedge sys_clk); i++; end
    while (lg !== 1'b1 && i < 3000) begin @(negedge sys_clk); i++; end
    while (lg === 1'b1 && per < 3000) begin @(negedge sys_clk); hi++; per++; end
    while (lg !== 1'b1 && per < 3000) begin @(negedge sys_clk); per++; end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic start_up(input logic [7:0] code);
    int i, bad;
    i = 0; bad = 0;
    @(posedge sys_clk);
    set_code <= code;
    en <= 1'b1;
    while (irc !== 1'b1 && i < 100) begin @(negedge sys_clk); i++; end
    chk(irc, 1);
    while (on !== 1'b1 && i < 40000) begin
      @(negedge sys_clk); i++;
      if (irc === 1'b1 && lg !== 1'b0) bad++;
    end
    chk(bad, 0);
    chk(level, code);
    chk(gd, code > 8'(och_pkg::GUARD_OFF_CODE));
  endtask

  task automatic ramp_switch;
    int i, t, hi, per;
    i = 0; t = 0;
    while (ramp !== 7'h01 && i < 100) begin @(negedge sys_clk); i++; end
    while (ramp !== 7'h02 && t < 100) begin @(negedge sys_clk); t++; end
    chk(t, 10);
    while (ramp !== 7'h40 && i < 800) begin @(negedge sys_clk); i++; end
    chk(ramp, 7'h40);
    measure(hi, per);
    chk(per, 416);
    chk(hi, 216);
    @(posedge sys_clk);
    duty <= 9'h1A0;
    measure(hi, per);
    measure(hi, per);
    chk(hi, 107);
    chk(per, 1248);
    @(posedge sys_clk);
    duty <= 9'h0C8;
    measure(hi, per);
  endtask

  task automatic short_retry;
    int i, n, t, bad;
    logic [7:0] held;
    held = level; bad = 0;
    @(posedge sys_clk);
    load_code <= {level, 1'b0};
    repeat (2000) begin @(negedge sys_clk); if (trip !== 1'b0) bad++; end
    chk(bad, 0);
    @(posedge sys_clk);
    load_code <= {level, 1'b0} + 9'h001;
    i = 0;
    while (trip !== 1'b1 && i < 1000) begin @(negedge sys_clk); i++; end
    chk(trip, 1);
    chk({hg, lg, on, hic}, 4'h1);
    for (int r = 0; r < 3; r++) begin
      n = 0; t = 0;
      @(negedge sys_clk);
      while (hic === 1'b1 && n < 3000) begin @(negedge sys_clk); n++; end
      chk(n + 1, 1280);
      t = n + 1;
      while (trip !== 1'b1 && t < 3000) begin @(negedge sys_clk); t++; end
      chk(trip, 1);
      chk(t >= 1280 && t <= 1920, 1);
      chk(level, held);
    end
    @(posedge sys_clk);
    load_code <= 9'h000;
    i = 0;
    while (ramp !== 7'h40 && i < 3000) begin @(negedge sys_clk); i++; end
    repeat (1000) begin @(negedge sys_clk); if (trip !== 1'b0 || on !== 1'b1) bad++; end
    chk(bad, 0);
  endtask

  task automatic reenable;
    @(posedge sys_clk);
    en <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk({hg, lg, on}, 3'h0);
    chk(level, 8'h05);
    start_up(8'h08);
  endtask

  // Setting above the bound: heavy load must never trip
  task automatic guard_off;
    int bad;
    bad = 0;
    @(posedge sys_clk);
    en <= 1'b0;
    repeat (5) @(negedge sys_clk);
    start_up(8'hA0);
    @(posedge sys_clk);
    load_code <= 9'h1FF;
    repeat (2000) begin @(negedge sys_clk); if (trip !== 1'b0 || on !== 1'b1 || hic !== 1'b0) bad++; end
    chk(bad, 0);
    chk(gd, 1);
    @(posedge sys_clk);
    load_code <= 9'h000;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    bias_ok <= 1'b1;
    repeat (4) @(posedge sys_clk);
    start_up(8'h05);
    ramp_switch;
    short_retry;
    reenable;
    guard_off;
    final_report;
  end

  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule
